// >>> core/sid_top.sv
// sid_top: local-bus decode strobes, snooped enables and own io ports of the dma companion
// assumes: host bus inputs share i_ref_clk; test, half-speed and coprocessor ready come from pins
`timescale 1ns/1ps
`include "sid_consts.svh"
module sid_top
  import sid_pkg::*;
#(
  parameter int STROBE_CLKS = `SID_STROBE_CLKS
) (
  input logic i_ref_clk,
  input logic i_nrst,
  input logic i_test_n,
  input logic i_half_speed,
  input logic i_coproc_ready_out_n,
  input logic i_ads_n,
  input logic [31:2] i_addr,
  input logic [3:0] i_be_n,
  input logic i_mio,
  input logic i_dc,
  input logic i_wr,
  input logic i_ready_n,
  input logic i_na_n,
  input logic i_hlda,
  input logic [31:0] i_data,
  input logic i_mst_req,
  input logic [31:2] i_mst_addr,
  input logic [3:0] i_mst_be_n,
  input logic [2:0] i_mst_type,
  input logic i_mst_pipe,
  output logic o_mst_ack,
  output logic o_mst_done,
  output logic o_ads_n,
  output logic [31:2] o_addr,
  output logic [3:0] o_be_n,
  output logic [2:0] o_type,
  output logic o_bus_oe,
  output logic [31:0] o_data,
  output logic o_data_oe,
  output logic o_coproc_addr_strobe_out_n,
  output logic o_parity_check_enable_out,
  output logic o_ext_data_reg_select,
  output logic o_video_ram_decode,
  output logic o_card_setup_decode,
  output logic o_dma_lo_decode,
  output logic o_dma_hi_decode,
  output logic o_page_lo_decode,
  output logic o_page_hi_decode,
  output logic o_local_io,
  output logic [7:0] o_arb_point,
  output logic o_out_oe
);
  localparam int CNT_W = $clog2(STROBE_CLKS + 1);

  // pins pass two flops before any logic reads them
  logic [2:0] pin_sync;
  logic test_ok;
  logic half_speed;
  logic cp_ready_n;
  sid_sync #(.WIDTH(3)) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async({i_test_n, i_half_speed, i_coproc_ready_out_n}),
    .o_sync(pin_sync)
  );
  assign test_ok = pin_sync[2];
  assign half_speed = pin_sync[1];
  assign cp_ready_n = pin_sync[0];

  function automatic logic [1:0] lo_addr(input logic [3:0] be_n);
    casez (be_n)
      4'b???0: lo_addr = 2'h0;
      4'b??01: lo_addr = 2'h1;
      4'b?011: lo_addr = 2'h2;
      default: lo_addr = 2'h3;
    endcase
  endfunction

  function automatic logic in_range(input logic [15:0] p, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (p >= lo) && (p <= hi);
  endfunction

  // current cycle and one pipelined successor seen on the host bus
  logic cur_valid_reg, cur_valid_next;
  logic [31:2] cur_addr_reg, cur_addr_next;
  logic [1:0] cur_lo_reg, cur_lo_next;
  logic [2:0] cur_type_reg, cur_type_next;
  logic pend_valid_reg, pend_valid_next;
  logic [31:2] pend_addr_reg, pend_addr_next;
  logic [1:0] pend_lo_reg, pend_lo_next;
  logic [2:0] pend_type_reg, pend_type_next;
  logic end_cyc;
  logic new_cyc;

  assign end_cyc = cur_valid_reg && !i_ready_n;

  // a new strobe during an open cycle is parked until the open one takes ready
  always_comb begin
    cur_valid_next = cur_valid_reg;
    cur_addr_next = cur_addr_reg;
    cur_lo_next = cur_lo_reg;
    cur_type_next = cur_type_reg;
    pend_valid_next = pend_valid_reg;
    pend_addr_next = pend_addr_reg;
    pend_lo_next = pend_lo_reg;
    pend_type_next = pend_type_reg;
    new_cyc = 1'b0;
    if (end_cyc) begin // R17
      cur_valid_next = pend_valid_reg;
      cur_addr_next = pend_addr_reg;
      cur_lo_next = pend_lo_reg;
      cur_type_next = pend_type_reg;
      pend_valid_next = 1'b0;
      new_cyc = pend_valid_reg;
    end
    if (!i_ads_n) begin
      if (!cur_valid_next) begin
        cur_valid_next = 1'b1;
        cur_addr_next = i_addr;
        cur_lo_next = lo_addr(i_be_n);
        cur_type_next = {i_mio, i_dc, i_wr};
        new_cyc = 1'b1;
      end else begin
        pend_valid_next = 1'b1;
        pend_addr_next = i_addr;
        pend_lo_next = lo_addr(i_be_n);
        pend_type_next = {i_mio, i_dc, i_wr};
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cur_valid_reg <= 1'b0;
      cur_addr_reg <= '0;
      cur_lo_reg <= 2'h0;
      cur_type_reg <= 3'h0;
      pend_valid_reg <= 1'b0;
      pend_addr_reg <= '0;
      pend_lo_reg <= 2'h0;
      pend_type_reg <= 3'h0;
    end else begin
      cur_valid_reg <= cur_valid_next;
      cur_addr_reg <= cur_addr_next;
      cur_lo_reg <= cur_lo_next;
      cur_type_reg <= cur_type_next;
      pend_valid_reg <= pend_valid_next;
      pend_addr_reg <= pend_addr_next;
      pend_lo_reg <= pend_lo_next;
      pend_type_reg <= pend_type_next;
    end
  end

  // decode of the cycle that will be current after this edge
  logic [15:0] nxt_port;
  logic [15:0] cur_port;
  logic nxt_io, nxt_mem, cur_io;
  logic [15:0] ext_ptr_reg;
  logic [7:0] ext_func_reg;
  logic [7:0] arb_point_reg;
  logic video_en_reg;
  logic parity_en_reg;
  logic dec_dma_lo, dec_dma_hi, dec_page_lo, dec_page_hi, dec_setup, dec_coproc;
  logic dec_ext, dec_video, dec_own, dec_read;
  logic [7:0] rd_byte;

  assign nxt_port = {cur_addr_next[15:2], cur_lo_next};
  assign cur_port = {cur_addr_reg[15:2], cur_lo_reg};
  // io cycles never carry upper address bits; halt cycles are not memory
  assign nxt_io = cur_valid_next && !cur_type_next[`SID_TYPE_MIO] &&
                  cur_type_next[`SID_TYPE_DC] && (cur_addr_next[31:16] == 16'h0000);
  assign nxt_mem = cur_valid_next && cur_type_next[`SID_TYPE_MIO] &&
                   (cur_type_next[`SID_TYPE_DC] || !cur_type_next[`SID_TYPE_WR]);
  assign cur_io = cur_valid_reg && !cur_type_reg[`SID_TYPE_MIO] &&
                  cur_type_reg[`SID_TYPE_DC] && (cur_addr_reg[31:16] == 16'h0000);

  assign dec_dma_lo = nxt_io && in_range(nxt_port, `SID_DMA_LO_FIRST, `SID_DMA_LO_LAST); // R10
  assign dec_dma_hi = nxt_io && !nxt_port[0] &&
                      in_range(nxt_port, `SID_DMA_HI_FIRST, `SID_DMA_HI_LAST); // R11
  assign dec_page_lo = nxt_io && (in_range(nxt_port, `SID_PAGE_LO_FIRST, `SID_PAGE_LO_LAST) ||
                       nxt_port == `SID_PAGE_LO_EXTRA); // R12
  assign dec_page_hi = nxt_io && (in_range(nxt_port, `SID_PAGE_HI_FIRST, `SID_PAGE_HI_LAST) ||
                       nxt_port == `SID_PAGE_HI_EXTRA); // R13
  assign dec_setup = nxt_io && in_range(nxt_port, `SID_SETUP_FIRST, `SID_SETUP_LAST); // R6
  assign dec_coproc = nxt_io && in_range(nxt_port, `SID_COPROC_FIRST, `SID_COPROC_LAST);
  assign dec_ext = nxt_io && (nxt_port == ext_ptr_reg); // R3
  assign dec_video = nxt_mem && video_en_reg &&
                     (cur_addr_next[31:17] == `SID_VIDEO_TAG); // R4 R5
  // ports answered here keep the expansion channel idle, except ports 3C3H and E1H
  assign dec_own = dec_dma_lo || dec_dma_hi || dec_page_lo || dec_page_hi || dec_coproc ||
                   (nxt_io && (nxt_port == `SID_EXT_FUNC_PORT || nxt_port == `SID_EXT_EXEC_PORT ||
                   nxt_port == `SID_ARB_POINT_PORT)); // R15
  assign dec_read = nxt_io && !cur_type_next[`SID_TYPE_WR] &&
                    (nxt_port == `SID_EXT_FUNC_PORT || nxt_port == `SID_ARB_POINT_PORT ||
                    nxt_port == `SID_VIDEO_EN_PORT);

  // read mux; the byte is copied to every lane so no lane steering is needed
  always_comb begin
    rd_byte = 8'h00;
    if (nxt_port == `SID_EXT_FUNC_PORT) begin
      rd_byte = ext_func_reg;
    end else if (nxt_port == `SID_ARB_POINT_PORT) begin
      rd_byte = arb_point_reg;
    end else if (nxt_port == `SID_VIDEO_EN_PORT) begin
      rd_byte = {7'h00, video_en_reg};
    end
  end

  // registered decode strobes; all fall when no cycle is open
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dma_lo_decode <= 1'b0;
      o_dma_hi_decode <= 1'b0;
      o_page_lo_decode <= 1'b0;
      o_page_hi_decode <= 1'b0;
      o_card_setup_decode <= 1'b0;
      o_ext_data_reg_select <= 1'b0;
      o_video_ram_decode <= 1'b0;
      o_local_io <= 1'b0;
      o_data <= 32'h0000_0000;
      o_data_oe <= 1'b0;
    end else begin
      o_dma_lo_decode <= dec_dma_lo;
      o_dma_hi_decode <= dec_dma_hi;
      o_page_lo_decode <= dec_page_lo;
      o_page_hi_decode <= dec_page_hi;
      o_card_setup_decode <= dec_setup;
      o_ext_data_reg_select <= dec_ext;
      o_video_ram_decode <= dec_video;
      o_local_io <= dec_own;
      o_data <= {4{rd_byte}};
      o_data_oe <= test_ok && dec_read; // R7
    end
  end

  // register writes complete on ready, when the data lanes are valid
  logic wr_hit;
  logic [7:0] wr_byte;
  assign wr_hit = end_cyc && cur_io && cur_type_reg[`SID_TYPE_WR];
  assign wr_byte = i_data[{cur_lo_reg, 3'b000} +: 8];

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_func_reg <= `SID_EXT_FUNC_RST;
      ext_ptr_reg <= `SID_EXT_PTR_RST; // R14
      arb_point_reg <= `SID_ARB_POINT_RST;
      video_en_reg <= 1'b0;
      parity_en_reg <= 1'b0;
    end else if (wr_hit) begin
      if (cur_port == `SID_EXT_FUNC_PORT) begin
        ext_func_reg <= wr_byte;
      end
      if (cur_port == `SID_EXT_EXEC_PORT && ext_func_reg == `SID_PTR_LO_INDEX) begin
        ext_ptr_reg[7:0] <= wr_byte; // R14
      end
      if (cur_port == `SID_EXT_EXEC_PORT && ext_func_reg == `SID_PTR_HI_INDEX) begin
        ext_ptr_reg[15:8] <= wr_byte;
      end
      if (cur_port == `SID_ARB_POINT_PORT) begin
        arb_point_reg <= wr_byte;
      end
      if (cur_port == `SID_VIDEO_EN_PORT) begin
        video_en_reg <= wr_byte[`SID_VIDEO_EN_BIT]; // R4
      end
      if (cur_port == `SID_MEM_ENC_PORT) begin
        parity_en_reg <= wr_byte[`SID_PARITY_BIT]; // R2
      end
    end
  end
  assign o_parity_check_enable_out = parity_en_reg; // R2
  assign o_arb_point = arb_point_reg;

  // half-speed coprocessor: strobe, then wait for its ready-out before another
  sid_cp_state_t cp_state_reg, cp_state_next;
  logic [CNT_W-1:0] cp_cnt_reg;
  always_comb begin
    cp_state_next = cp_state_reg;
    unique case (cp_state_reg)
      CP_IDLE: begin
        if (half_speed && new_cyc && dec_coproc) begin // R1
          cp_state_next = CP_STROBE;
        end
      end
      CP_STROBE: begin
        if (cp_cnt_reg == CNT_W'(STROBE_CLKS - 1)) begin
          cp_state_next = CP_WAIT;
        end
      end
      CP_WAIT: begin
        if (!cp_ready_n) begin // R16
          cp_state_next = CP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cp_state_reg <= CP_IDLE;
      cp_cnt_reg <= '0;
      o_coproc_addr_strobe_out_n <= 1'b1;
    end else begin
      cp_state_reg <= cp_state_next;
      // count only once inside the strobe state, so the strobe stays low for STROBE_CLKS edges
      cp_cnt_reg <= (cp_state_reg == CP_STROBE) ? cp_cnt_reg + CNT_W'(1) : '0;
      o_coproc_addr_strobe_out_n <= (cp_state_next != CP_STROBE); // R1
    end
  end

  // test low floats every driven line; bus outputs only while the bus is ours
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_out_oe <= 1'b0;
      o_bus_oe <= 1'b0;
    end else begin
      o_out_oe <= test_ok; // R7
      o_bus_oe <= test_ok && i_hlda; // R7
    end
  end

  sid_bus_master u_master (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_req(i_mst_req),
    .i_addr(i_mst_addr),
    .i_be_n(i_mst_be_n),
    .i_type(i_mst_type),
    .i_pipe(i_mst_pipe),
    .i_hlda(i_hlda),
    .i_ready_n(i_ready_n),
    .i_na_n(i_na_n),
    .o_ads_n(o_ads_n),
    .o_addr(o_addr),
    .o_be_n(o_be_n),
    .o_type(o_type),
    .o_ack(o_mst_ack),
    .o_done(o_mst_done)
  );

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_parity_copy: assert property ((wr_hit && cur_port == `SID_MEM_ENC_PORT) |=> // R2
    o_parity_check_enable_out == $past(wr_byte[0])) else $error("parity enable not copied");
  a_ext_select: assert property (o_ext_data_reg_select |-> cur_io && cur_port == ext_ptr_reg) // R3
    else $error("extended select without pointer match");
  a_video_gate: assert property (o_video_ram_decode |-> $past(video_en_reg)) // R4
    else $error("video decode while disabled");
  a_video_range: assert property (o_video_ram_decode |-> cur_addr_reg[31:17] == 15'h0005) // R5
    else $error("video decode outside window");
  a_setup_range: assert property (o_card_setup_decode |-> cur_io && // R6
    cur_port >= 16'h0100 && cur_port <= 16'h0107) else $error("card setup decode out of range");
  a_test_float: assert property (!test_ok |=> !o_out_oe && !o_data_oe && !o_bus_oe) // R7
    else $error("outputs enabled during test");
  a_dma_lo: assert property ((cur_io && cur_port <= 16'h000F) |-> o_dma_lo_decode) // R10
    else $error("low dma port not decoded");
  a_dma_hi_odd: assert property (o_dma_hi_decode |-> !cur_port[0]) // R11
    else $error("odd high dma port decoded");
  a_page_lo: assert property ((cur_io && cur_port == 16'h0087) |-> o_page_lo_decode) // R12
    else $error("page port 87 not decoded");
  a_page_hi: assert property ((cur_io && cur_port == 16'h009F) |-> o_page_hi_decode) // R13
    else $error("page port 9f not decoded");
  a_local_quiet: assert property (o_dma_lo_decode |-> o_local_io) // R15
    else $error("own port left to channel");
  sequence s_strobe_low;
    !o_coproc_addr_strobe_out_n ##1 o_coproc_addr_strobe_out_n;
  endsequence
  a_strobe_len: assert property ($fell(o_coproc_addr_strobe_out_n) |=> s_strobe_low) // R1
    else $error("coprocessor strobe width wrong");
  a_strobe_hold: assert property ((cp_state_reg == CP_WAIT && cp_ready_n) |=> // R16
    cp_state_reg == CP_WAIT) else $error("strobe rearmed before ready-out");
  a_idle_quiet: assert property (!cur_valid_reg |-> !o_dma_lo_decode && !o_card_setup_decode &&
    !o_video_ram_decode && !o_ext_data_reg_select) // R17
    else $error("decode without a cycle");
endmodule // sid_top

// >>> core/sid_consts.svh
// sid_consts.svh: port offsets, field positions, reset values and counts of the io decode block
// assumes: a 32-bit host bus with byte-wide io ports, clocked at the double-rate processor clock
// Overview of operation
// R1 - in half-speed mode drive a coprocessor address strobe; idle in full-speed mode
// R2 - parity check enable output copies bit 0 of memory encoding port E1H
// R3 - extended data select asserts when the io address equals the pointer value
// R4 - video memory decode only while bit 0 of port 3C3H is set
// R5 - video decode checks upper address bits for the A0000H to BFFFFH window
// R6 - card setup decode asserts for io cycles to 100H through 107H
// R7 - test input low floats every output and bidirectional line
// R8 - as bus owner, run non-pipelined cycles identical to processor cycles
// R9 - as bus owner, also run pipelined cycles identical to processor ones
// R10 - decode io 0000H to 000FH as low-group dma registers
// R11 - decode even io 00C0H to 00DFH as high-group dma registers
// R12 - decode io 0081H to 0083H and 0087H as low-group page registers
// R13 - decode io 0089H to 008BH and 009FH as high-group page registers
// R14 - extended data register answers at 0700H after reset, movable later
// R15 - internally decoded io addresses must not start an expansion channel cycle; reads of 3C3H are answered without o_local_io
// R16 - in half-speed mode track coprocessor cycles with its ready-out input
// R17 - decodes follow the current cycle and drop when no cycle is valid
`ifndef SID_CONSTS_SVH
`define SID_CONSTS_SVH
`define SID_EXT_FUNC_PORT 16'h0018
`define SID_EXT_EXEC_PORT 16'h001A
`define SID_ARB_POINT_PORT 16'h0090
`define SID_MEM_ENC_PORT 16'h00E1
`define SID_VIDEO_EN_PORT 16'h03C3
`define SID_EXT_PTR_RST 16'h0700
`define SID_EXT_FUNC_RST 8'h00
`define SID_ARB_POINT_RST 8'h00
`define SID_PTR_LO_INDEX 8'h00
`define SID_PTR_HI_INDEX 8'h01
`define SID_PARITY_BIT 0
`define SID_VIDEO_EN_BIT 0
`define SID_DMA_LO_FIRST 16'h0000
`define SID_DMA_LO_LAST 16'h000F
`define SID_DMA_HI_FIRST 16'h00C0
`define SID_DMA_HI_LAST 16'h00DF
`define SID_PAGE_LO_FIRST 16'h0081
`define SID_PAGE_LO_LAST 16'h0083
`define SID_PAGE_LO_EXTRA 16'h0087
`define SID_PAGE_HI_FIRST 16'h0089
`define SID_PAGE_HI_LAST 16'h008B
`define SID_PAGE_HI_EXTRA 16'h009F
`define SID_SETUP_FIRST 16'h0100
`define SID_SETUP_LAST 16'h0107
`define SID_COPROC_FIRST 16'h00F8
`define SID_COPROC_LAST 16'h00FF
`define SID_VIDEO_TAG 15'h0005
`define SID_TYPE_MIO 2
`define SID_TYPE_DC 1
`define SID_TYPE_WR 0
`define SID_STROBE_CLKS 2
`define SID_BUS_STATE_CLKS 2
`endif

// >>> core/sid_pkg.sv
// sid_pkg: state types of the io decode block
// assumes: sid_consts.svh supplies every number
package sid_pkg;
  typedef enum logic [1:0] {MST_IDLE, MST_T1, MST_T2} sid_mst_state_t;
  typedef enum logic [1:0] {CP_IDLE, CP_STROBE, CP_WAIT} sid_cp_state_t;
endpackage

// >>> core/sid_sync.sv
// sid_sync: two-flop level synchroniser, one lane per bit
// assumes: inputs are slow levels from pins; resets to zero
`timescale 1ns/1ps
module sid_sync #(
  parameter int WIDTH = 1
) (
  input logic i_ref_clk,
  input logic i_nrst,
  input logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  genvar g;
  // first flop feeds only the second
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          meta_reg[g] <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          meta_reg[g] <= i_async[g];
          o_sync[g] <= meta_reg[g];
        end
      end
    end
  endgenerate
endmodule // sid_sync

// >>> core/sid_bus_master.sv
// sid_bus_master: drives processor-style bus cycles while this device owns the local bus
// assumes: hold acknowledge, ready and next-address come from logic on the same clock
`timescale 1ns/1ps
`include "sid_consts.svh"
module sid_bus_master
  import sid_pkg::*;
#(
  parameter int STATE_CLKS = `SID_BUS_STATE_CLKS
) (
  input logic i_ref_clk,
  input logic i_nrst,
  input logic i_req,
  input logic [31:2] i_addr,
  input logic [3:0] i_be_n,
  input logic [2:0] i_type,
  input logic i_pipe,
  input logic i_hlda,
  input logic i_ready_n,
  input logic i_na_n,
  output logic o_ads_n,
  output logic [31:2] o_addr,
  output logic [3:0] o_be_n,
  output logic [2:0] o_type,
  output logic o_ack,
  output logic o_done
);
  localparam int CW = $clog2(STATE_CLKS + 1);
  sid_mst_state_t state_reg;
  logic [CW-1:0] ads_cnt_reg;
  logic piped_reg;
  logic take_first;
  logic take_pipe;
  logic ads_last;

  // o_ack blocks a second take while the requester still holds its level
  assign take_first = (state_reg == MST_IDLE) && i_req && i_hlda && !o_ack;
  assign take_pipe = (state_reg == MST_T2) && i_pipe && !i_na_n && i_req && !piped_reg &&
                     !o_ack && o_ads_n && i_ready_n;
  assign ads_last = !o_ads_n && (ads_cnt_reg == CW'(STATE_CLKS - 1));

  // address phase: strobe stays low for one full bus state
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ads_n <= 1'b1;
      o_addr <= '0;
      o_be_n <= 4'hF;
      o_type <= 3'h0;
      o_ack <= 1'b0;
      ads_cnt_reg <= '0;
    end else begin
      o_ack <= take_first || take_pipe;
      if (take_first || take_pipe) begin // R8 R9
        o_ads_n <= 1'b0;
        o_addr <= i_addr;
        o_be_n <= i_be_n;
        o_type <= i_type;
        ads_cnt_reg <= '0;
      end else if (ads_last) begin
        o_ads_n <= 1'b1;
      end else if (!o_ads_n) begin
        ads_cnt_reg <= ads_cnt_reg + CW'(1);
      end
    end
  end

  // cycle phases; piped_reg marks a pipelined address already issued, until the current ready
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= MST_IDLE;
      piped_reg <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (state_reg)
        MST_IDLE: begin
          if (take_first) begin
            state_reg <= MST_T1;
          end
        end
        MST_T1: begin
          if (ads_last) begin
            state_reg <= MST_T2;
          end
        end
        MST_T2: begin
          if (!i_ready_n) begin // R8
            o_done <= 1'b1;
            piped_reg <= 1'b0;
            state_reg <= piped_reg ? ((o_ads_n) ? MST_T2 : MST_T1) : MST_IDLE; // R9
          end else if (take_pipe) begin
            piped_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_ads_width: assert property ($fell(o_ads_n) |=> !o_ads_n ##1 o_ads_n) // R8
    else $error("address strobe not one bus state wide");
  a_done_ready: assert property ((state_reg == MST_T2 && !i_ready_n) |=> o_done) // R8
    else $error("ready did not complete the owned cycle");
  a_pipe_issue: assert property (take_pipe |=> !o_ads_n && piped_reg && state_reg == MST_T2) // R9
    else $error("pipelined address not issued during current cycle");
endmodule // sid_bus_master

// >>> verif/sid_host_model.sv
// sid_host_model: far side of the bus, answers strobes with ready and models coprocessor ready-out
// assumes: shares the block clock; ready rests high on its pull-up between cycles
`timescale 1ns/1ps
module sid_host_model (
  input wire logic i_ref_clk,
  input wire logic i_ads_n,
  input wire logic [1:0] i_wait,
  input wire logic i_cp_strobe_n,
  output logic o_ready_n = 1'b1,
  output logic o_cp_ready_n = 1'b1
);
  int cnt = -1;
  int cp = -1;
  logic ads_q = 1'b1;
  logic pend = 1'b0;
  // ready is one cycle wide, i_wait cycles after a strobe ends; a strobe that ends
  // during an open cycle waits in pend, so a pipelined address gets its own ready
  always @(posedge i_ref_clk) begin
    if (cnt == 0) begin
      cnt = pend ? int'(i_wait) : -1;
      pend = 1'b0;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
    end
    if (i_ads_n && !ads_q) begin
      if (cnt < 0) begin
        cnt = int'(i_wait);
      end else begin
        pend = 1'b1;
      end
    end
    ads_q = i_ads_n;
    cp = !i_cp_strobe_n ? 3 : cp - 1;
    #2;
    o_ready_n = cnt != 0;
    o_cp_ready_n = cp != 0;
  end
endmodule // sid_host_model

// >>> verif/sid_top_tb_top.sv
// sid_top_tb_top: random and corner io, memory and owned cycles against the decode block
// assumes: sid_host_model answers every strobe; this bench plays the host processor
`timescale 1ns/1ps
module sid_top_tb_top;
  logic i_ref_clk = 1'b0, i_nrst = 1'b0, test_n = 1'b1, half = 1'b0, ads_n = 1'b1, seen;
  logic mio = 1'b0, dc = 1'b0, wr = 1'b0, hlda = 1'b0, req = 1'b0, ven = 1'b0, rdy_n, cprdy_n;
  logic [31:2] addr = '0, maddr = '0, o_addr;
  logic [31:0] data = '0, o_data;
  logic [3:0] be_n = 4'hF, o_be_n;
  logic [2:0] o_type;
  logic [1:0] wt = 2'h0;
  logic [7:0] arb, rd, d;
  logic [15:0] ptr = 16'h0700;
  logic ack, done, o_ads_n, bus_oe, data_oe, cp_n, par, esel, vid, card, dlo, dhi, plo, phi, lio;
  logic oe, na_n = 1'b1, pipe = 1'b0;
  logic [15:0] cor [20] = '{16'h0000, 16'h000F, 16'h0010, 16'h0018, 16'h001A, 16'h0081,
    16'h0083, 16'h0084, 16'h0087, 16'h0089, 16'h008B, 16'h009F, 16'h0090, 16'h00C0,
    16'h00C1, 16'h00DF, 16'h00E0, 16'h0100, 16'h0107, 16'h0700};
  int n_mismatch = 0, num_checks = 0, seed = 34, i;
  // free-running clock
  always #50 i_ref_clk = ~i_ref_clk;
  sid_top i_sid_top (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_test_n(test_n),
    .i_half_speed(half), .i_coproc_ready_out_n(cprdy_n), .i_ads_n(ads_n), .i_addr(addr),
    .i_be_n(be_n), .i_mio(mio), .i_dc(dc), .i_wr(wr), .i_ready_n(rdy_n), .i_na_n(na_n),
    .i_hlda(hlda), .i_data(data), .i_mst_req(req), .i_mst_addr(maddr), .i_mst_be_n(4'h0),
    .i_mst_type(3'b110), .i_mst_pipe(pipe), .o_mst_ack(ack), .o_mst_done(done),
    .o_ads_n(o_ads_n), .o_addr(o_addr), .o_be_n(o_be_n), .o_type(o_type), .o_bus_oe(bus_oe),
    .o_data(o_data), .o_data_oe(data_oe), .o_coproc_addr_strobe_out_n(cp_n),
    .o_parity_check_enable_out(par), .o_ext_data_reg_select(esel), .o_video_ram_decode(vid),
    .o_card_setup_decode(card), .o_dma_lo_decode(dlo), .o_dma_hi_decode(dhi),
    .o_page_lo_decode(plo), .o_page_hi_decode(phi), .o_local_io(lio), .o_arb_point(arb),
    .o_out_oe(oe));
  sid_host_model i_sid_host_model (.i_ref_clk(i_ref_clk), .i_ads_n(ads_n & (o_ads_n | !bus_oe)),
    .i_wait(wt), .i_cp_strobe_n(cp_n), .o_ready_n(rdy_n), .o_cp_ready_n(cprdy_n));
  wire [7:0] dv = {esel, card, dlo, dhi, plo, phi, lio, vid};
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // inputs move 5 ns after the edge so the block never sees them change at its sampling point
  task automatic tick(int n = 1);
    repeat (n) @(posedge i_ref_clk);
    #5;
    seen |= !cp_n;
  endtask
  // waits for ready low (0), ack high (1) or done high (2); unknowns keep it waiting
  task automatic await(int w);
    for (int k = 0; (w == 0 ? rdy_n : w == 1 ? !ack : !done) !== 1'b0; k++) begin
      if (k > 20) begin
        n_mismatch++;
        results();
      end
      tick();
    end
  endtask
  // expected {select, setup, dma lo, dma hi, page lo, page hi, local, video}
  function automatic logic [7:0] dec(logic [31:0] a, logic m);
    logic [15:0] p;
    logic lo, hi, pl, ph;
    p = a[15:0];
    lo = p <= 16'h000F;
    hi = p >= 16'h00C0 && p <= 16'h00DF && !p[0];
    pl = p inside {[16'h0081:16'h0083], 16'h0087};
    ph = p inside {[16'h0089:16'h008B], 16'h009F};
    if (m) return {7'h00, ven && a[31:17] == 15'h0005};
    return {p == ptr, p inside {[16'h0100:16'h0107]}, lo, hi, pl, ph,
      lo | hi | pl | ph | (p inside {16'h0018, 16'h001A, 16'h0090, [16'h00F8:16'h00FF]}), 1'b0};
  endfunction
  // one host cycle: strobe, decode check, ready from the model, then the idle check
  task automatic cyc(logic [31:0] a, logic [2:0] t, logic [7:0] v);
    logic re;
    re = !t[2] && !t[0] && (a[15:0] inside {16'h0018, 16'h0090, 16'h03C3});
    {mio, dc, wr} = t;
    addr = a[31:2];
    be_n = ~(4'h1 << a[1:0]);
    data = {4{v}};
    ads_n = 1'b0;
    tick();
    ads_n = 1'b1;
    chk("decode", dec(a, t[2]), dv);
    chk("read enable", re, data_oe);
    rd = o_data[7:0];
    await(0);
    tick();
    chk("idle", 8'h00, dv);
  endtask
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_ref_clk);
    #5 i_nrst = 1'b1;
    tick(3);
    chk("reset", 32'h3, {par, arb, cp_n, oe});
    for (i = 0; i < 80; i++) begin
      wt = 2'($random(seed));
      cyc(i < 20 ? {16'h0, cor[i]} : 32'($random(seed)) & 32'h01FF, 3'b010, 8'h00);
    end
    d = 8'($random(seed));
    cyc(32'h90, 3'b011, d);
    chk("arb", d, arb);
    cyc(32'h90, 3'b010, 8'h00);
    chk("readback", d, rd);
    cyc(32'hE1, 3'b011, 8'h01);
    chk("parity", 1, par);
    cyc(32'h18, 3'b011, 8'h00);
    cyc(32'h1A, 3'b011, 8'h34);
    cyc(32'h18, 3'b011, 8'h01);
    cyc(32'h1A, 3'b011, 8'h05);
    ptr = 16'h0534;
    cyc(32'h534, 3'b010, 8'h00);
    cyc(32'h700, 3'b010, 8'h00);
    cyc(32'hA0000, 3'b110, 8'h00);
    cyc(32'h3C3, 3'b011, 8'h01);
    ven = 1'b1;
    cyc(32'hA0000, 3'b110, 8'h00);
    cyc(32'hBFFFC, 3'b110, 8'h00);
    cyc(32'hC0000, 3'b110, 8'h00);
    wt = 2'h3;
    seen = 1'b0;
    cyc(32'hF8, 3'b010, 8'h00);
    chk("cp full", 0, seen);
    for (i = 0; i < 2; i++) begin
      half = 1'b1;
      tick(8);
      seen = 1'b0;
      cyc(32'hFC, 3'b010, 8'h00);
      chk("cp half", 1, seen);
    end
    hlda = 1'b1;
    for (i = 0; i < 2; i++) begin
      wt = 2'(2 * i);
      maddr = 30'($random(seed));
      req = 1'b1;
      await(1);
      req = 1'b0;
      chk("owned", {maddr, 9'h019}, {o_addr, o_be_n, o_type, o_ads_n, bus_oe});
      await(2);
      tick();
    end
    // pipelined: the second address goes out in T2 of the first cycle, before its ready
    {wt, pipe, na_n} = 4'hE;
    for (i = 0; i < 2; i++) begin
      maddr = 30'($random(seed));
      req = 1'b1;
      await(1);
      req = 1'b0;
      chk("piped", {maddr, 9'h019}, {o_addr, o_be_n, o_type, o_ads_n, bus_oe});
      if (i == 0) tick(2);
    end
    await(2);
    tick();
    await(2);
    tick();
    test_n = 1'b0;
    tick(4);
    chk("float", 0, {oe, bus_oe, data_oe});
    results();
  end
endmodule // sid_top_tb_top
